// File: spm_pkg.sv
// constants, types and register layout for the strap latch
// assumes the pins are sampled in the 100 MHz clk_in domain
package spm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // least low time of the device reset pin that counts as a full reset
  localparam int FULL_RESET_MIN_NS = 2000;
  localparam int FULL_RESET_CYCLES = (FULL_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // positions inside the shared bus, index 0 is parallel_data_bit9
  localparam int DB_BYTE_STRAP = 0;
  localparam int DB_SERIAL_CFG = 1;
  localparam int DB_SERIAL_B = 2;
  localparam int DB_SERIAL_A = 3;
  localparam int DB_OSR_LSB = 4;
  localparam int DB_WIDTH = 7;

  // apb register offsets
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] SW_RANGE_OFS = 12'h004;

  // status register fields
  localparam int ST_VALID_BIT = 0;
  localparam int ST_BYTE_BIT = 1;
  localparam int ST_SERIAL_BIT = 2;
  localparam int ST_SINGLE_BIT = 3;
  localparam int ST_OSR_LSB = 4;
  localparam int ST_CODE_LSB = 7;
  localparam int ST_HW_BIT = 9;
  localparam int ST_RANGE_LSB = 10;

  // range codes
  localparam logic [1:0] RANGE_SW_CODE = 2'h0;
  localparam logic [1:0] RANGE_2V5 = 2'h1;
  localparam logic [1:0] RANGE_5V = 2'h2;
  localparam logic [1:0] RANGE_10V = 2'h3;
  localparam logic [1:0] SW_RANGE_RESET = 2'h3;

  typedef enum logic [2:0] {
    MODE_PAR = 3'b001,
    MODE_BYTE = 3'b010,
    MODE_SER = 3'b100
  } spm_mode_t;

  typedef enum logic [1:0] {
    RST_RUN = 2'b01,
    RST_LOW = 2'b10
  } spm_rst_state_t;

  typedef struct packed {
    logic valid;
    spm_mode_t mode;
    logic single_lane;
    logic [2:0] oversampling_ratio;
    logic [1:0] code;
    logic [1:0] range;
    logic [1:0] sw_range;
    logic [DB_WIDTH-1:0] db_out;
    logic [DB_WIDTH-1:0] db_oe_n;
    logic serial_cfg;
    logic [31:0] prdata;
  } spm_state_t;
endpackage

// File: spm_rst_classify.sv
// measures the low time of the device reset pin, tells full from partial
// assumes the pin is synchronous to clk_in
`timescale 1ns/10ps
module spm_rst_classify #(
  parameter int FULL_CYCLES = spm_pkg::FULL_RESET_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic dev_reset_n_in,
  output logic full_rel_out,
  output logic partial_rel_out,
  output logic in_reset_out
);
  import spm_pkg::*;

  localparam int CW = $clog2(FULL_CYCLES + 1);

  if (FULL_CYCLES < 2) begin : g_chk
    $error("full reset length must be at least two cycles");
  end

  typedef struct packed {
    spm_rst_state_t st;
    logic [CW-1:0] cnt;
    logic full;
    logic part;
  } spm_cls_t;

  spm_cls_t q_reg;
  spm_cls_t q_next;

  always_comb begin
    q_next = q_reg;
    q_next.full = 1'b0;
    q_next.part = 1'b0;
    case (q_reg.st)
      RST_RUN: begin
        if (!dev_reset_n_in) begin
          q_next.st = RST_LOW;
          q_next.cnt = CW'(1);
        end
      end
      RST_LOW: begin
        if (dev_reset_n_in) begin
          q_next.st = RST_RUN;
          if (q_reg.cnt >= CW'(FULL_CYCLES)) begin
            q_next.full = 1'b1;
          end else begin
            q_next.part = 1'b1;
          end
        end else if (q_reg.cnt < CW'(FULL_CYCLES)) begin
          q_next.cnt = q_reg.cnt + CW'(1);
        end
      end
      default: begin
        q_next.st = RST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q_reg <= '{st: RST_RUN, cnt: '0, full: 1'b0, part: 1'b0};
    end else if (ce_in) begin
      q_reg <= q_next;
    end
  end

  assign full_rel_out = q_reg.full;
  assign partial_rel_out = q_reg.part;
  assign in_reset_out = (q_reg.st == RST_LOW);

  property p_full_len;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.st == RST_LOW && dev_reset_n_in && q_reg.cnt >= CW'(FULL_CYCLES)) |=> full_rel_out && !partial_rel_out;
  endproperty
  a_full_len: assert property (p_full_len) else $error("long reset pulse not seen as full");

  property p_part_len;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.st == RST_LOW && dev_reset_n_in && q_reg.cnt < CW'(FULL_CYCLES)) |=> partial_rel_out && !full_rel_out;
  endproperty
  a_part_len: assert property (p_part_len) else $error("short reset pulse not seen as partial");

  c_full: cover property (@(posedge clk_in) disable iff (!reset_n_in) full_rel_out);
  c_part: cover property (@(posedge clk_in) disable iff (!reset_n_in) partial_rel_out);
endmodule

// File: spm_top.sv
// strap latch and shared pin steering for the converter's digital side
// assumes all pins and the apb bus are synchronous to clk_in
`timescale 1ns/10ps
module spm_top #(
  parameter int FULL_CYCLES = spm_pkg::FULL_RESET_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic dev_reset_n_in,
  input wire logic serial_mode_strap_in,
  input wire logic single_lane_strap_in,
  input wire logic range_mode_pin_hi_in,
  input wire logic range_mode_pin_lo_in,
  input wire logic [spm_pkg::DB_WIDTH-1:0] db_in,
  output logic [spm_pkg::DB_WIDTH-1:0] db_out,
  output logic [spm_pkg::DB_WIDTH-1:0] db_oe_n_out,
  input wire logic par_rd_in,
  input wire logic [spm_pkg::DB_WIDTH-1:0] par_data_in,
  input wire logic serial_a_bit_in,
  input wire logic serial_b_bit_in,
  output logic serial_cfg_out,
  output logic hw_mode_out,
  output logic [1:0] range_sel_out,
  output logic [2:0] oversampling_ratio_out,
  output logic [2:0] iface_mode_out,
  output logic single_lane_out,
  output logic straps_valid_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  import spm_pkg::*;

  spm_state_t q_reg;
  spm_state_t q_next;
  logic full_rel;
  logic part_rel;
  logic in_reset;
  logic [1:0] live_code;
  logic hw_mode;
  logic drive_ok;

  spm_rst_classify #(
    .FULL_CYCLES(FULL_CYCLES)
  ) u_cls (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .dev_reset_n_in(dev_reset_n_in),
    .full_rel_out(full_rel),
    .partial_rel_out(part_rel),
    .in_reset_out(in_reset)
  );

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == STATUS_OFS) || (a == SW_RANGE_OFS);
  endfunction

  assign live_code = {range_mode_pin_hi_in, range_mode_pin_lo_in};
  assign hw_mode = q_reg.valid && (q_reg.code != RANGE_SW_CODE);
  // no pin drive while the host may be driving straps
  assign drive_ok = q_reg.valid && !in_reset && dev_reset_n_in;

  always_comb begin
    q_next = q_reg;
    q_next.db_oe_n = '1;
    q_next.db_out = '0;
    q_next.serial_cfg = 1'b0;

    if (full_rel) begin
      q_next.valid = 1'b1;
      if (serial_mode_strap_in) begin
        q_next.mode = MODE_SER;
      end else if (db_in[DB_BYTE_STRAP]) begin
        q_next.mode = MODE_BYTE;
      end else begin
        q_next.mode = MODE_PAR;
      end
      q_next.single_lane = single_lane_strap_in;
      q_next.oversampling_ratio = db_in[DB_OSR_LSB +: 3];
      q_next.code = live_code;
      q_next.sw_range = SW_RANGE_RESET;
    end else if (part_rel) begin
      // partial reset keeps the straps, only clears software setup
      q_next.sw_range = SW_RANGE_RESET;
    end

    if (hw_mode) begin
      if (live_code != RANGE_SW_CODE) begin
        q_next.range = live_code;
      end
    end else begin
      q_next.range = q_reg.sw_range;
    end

    if (drive_ok) begin
      case (q_reg.mode)
        MODE_PAR: begin
          if (par_rd_in) begin
            q_next.db_out = par_data_in;
            q_next.db_oe_n = '0;
          end
        end
        MODE_SER: begin
          q_next.db_out[DB_SERIAL_A] = serial_a_bit_in;
          q_next.db_oe_n[DB_SERIAL_A] = 1'b0;
          // lane B only in two lane use
          if (!q_reg.single_lane) begin
            q_next.db_out[DB_SERIAL_B] = serial_b_bit_in;
            q_next.db_oe_n[DB_SERIAL_B] = 1'b0;
          end
          if (!hw_mode) begin
            q_next.serial_cfg = db_in[DB_SERIAL_CFG];
          end
        end
        MODE_BYTE: begin
          // host holds these low, nothing driven here
          q_next.db_oe_n = '1;
        end
        default: begin
          q_next.db_oe_n = '1;
        end
      endcase
    end

    // read data latched in setup so it comes from a flop in access
    if (psel_in && !penable_in && !pwrite_in) begin
      q_next.prdata = '0;
      if (paddr_in == STATUS_OFS) begin
        q_next.prdata[ST_VALID_BIT] = q_reg.valid;
        q_next.prdata[ST_BYTE_BIT] = (q_reg.mode == MODE_BYTE);
        q_next.prdata[ST_SERIAL_BIT] = (q_reg.mode == MODE_SER);
        q_next.prdata[ST_SINGLE_BIT] = q_reg.single_lane;
        q_next.prdata[ST_OSR_LSB +: 3] = q_reg.oversampling_ratio;
        q_next.prdata[ST_CODE_LSB +: 2] = q_reg.code;
        q_next.prdata[ST_HW_BIT] = hw_mode;
        q_next.prdata[ST_RANGE_LSB +: 2] = q_reg.range;
      end else if (paddr_in == SW_RANGE_OFS) begin
        q_next.prdata[1:0] = q_reg.sw_range;
      end
    end

    // software write; a full or partial release in the same cycle wins
    if (psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == SW_RANGE_OFS && !full_rel && !part_rel) begin
      if (pwdata_in[1:0] != RANGE_SW_CODE) begin
        q_next.sw_range = pwdata_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q_reg <= '{valid: 1'b0, mode: MODE_PAR, single_lane: 1'b0, oversampling_ratio: 3'h0, code: 2'h0,
                 range: SW_RANGE_RESET, sw_range: SW_RANGE_RESET, db_out: '0, db_oe_n: '1,
                 serial_cfg: 1'b0, prdata: 32'h00000000};
    end else if (ce_in) begin
      q_reg <= q_next;
    end
  end

  assign db_out = q_reg.db_out;
  assign db_oe_n_out = q_reg.db_oe_n;
  assign serial_cfg_out = q_reg.serial_cfg;
  assign hw_mode_out = hw_mode;
  assign range_sel_out = q_reg.range;
  assign oversampling_ratio_out = q_reg.oversampling_ratio;
  assign iface_mode_out = q_reg.mode;
  assign single_lane_out = q_reg.single_lane;
  assign straps_valid_out = q_reg.valid;
  assign prdata_out = q_reg.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_mapped(paddr_in);

  property p_par_drive;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && drive_ok && q_reg.mode == MODE_PAR && par_rd_in && !full_rel) |=>
      (db_oe_n_out == '0) && (db_out == $past(par_data_in));
  endproperty
  a_par_drive: assert property (p_par_drive) else $error("parallel bits not driven");

  property p_byte_cap;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && full_rel && !serial_mode_strap_in) |=> (iface_mode_out == MODE_BYTE) == $past(db_in[DB_BYTE_STRAP]);
  endproperty
  a_byte_cap: assert property (p_byte_cap) else $error("byte strap not captured");

  property p_cfg_in;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && drive_ok && q_reg.mode == MODE_SER && !hw_mode && !full_rel) |=>
      serial_cfg_out == $past(db_in[DB_SERIAL_CFG]);
  endproperty
  a_cfg_in: assert property (p_cfg_in) else $error("serial config input not passed");

  property p_lane_b;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.mode == MODE_SER && q_reg.single_lane && !full_rel) |=> db_oe_n_out[DB_SERIAL_B];
  endproperty
  a_lane_b: assert property (p_lane_b) else $error("lane B driven in single lane use");

  property p_lane_a;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && drive_ok && q_reg.mode == MODE_SER && !full_rel) |=>
      !db_oe_n_out[DB_SERIAL_A] && db_out[DB_SERIAL_A] == $past(serial_a_bit_in);
  endproperty
  a_lane_a: assert property (p_lane_a) else $error("lane A not driven");

  property p_osr_cap;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && full_rel) |=> oversampling_ratio_out == $past(db_in[DB_OSR_LSB +: 3]);
  endproperty
  a_osr_cap: assert property (p_osr_cap) else $error("oversampling straps not captured");

  property p_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
    !full_rel |=> $stable(oversampling_ratio_out) && $stable(iface_mode_out) && $stable(single_lane_out);
  endproperty
  a_hold: assert property (p_hold) else $error("straps changed without full reset");

  property p_hw_track;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && hw_mode && !full_rel && live_code != RANGE_SW_CODE) |=> range_sel_out == $past(live_code);
  endproperty
  a_hw_track: assert property (p_hw_track) else $error("hardware range not following pins");

  property p_sw_range;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.valid && !hw_mode && !full_rel) |=> range_sel_out == $past(q_reg.sw_range);
  endproperty
  a_sw_range: assert property (p_sw_range) else $error("software range follows pins");

  property p_code_mode;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && full_rel) |=> hw_mode_out == ($past(live_code) != RANGE_SW_CODE);
  endproperty
  a_code_mode: assert property (p_code_mode) else $error("mode code decoded wrong");

  property p_range_legal;
    @(posedge clk_in) disable iff (!reset_n_in)
    range_sel_out != RANGE_SW_CODE;
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("range select left at the zero code");

  property p_hw_keep;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && hw_mode && !full_rel && live_code == RANGE_SW_CODE) |=> $stable(range_sel_out);
  endproperty
  a_hw_keep: assert property (p_hw_keep) else $error("zero live code changed the range");

  property p_valid_cap;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && full_rel) |=> straps_valid_out && single_lane_out == $past(single_lane_strap_in);
  endproperty
  a_valid_cap: assert property (p_valid_cap) else $error("lane strap not captured");

  property p_byte_quiet;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.mode == MODE_BYTE) |=> db_oe_n_out == '1;
  endproperty
  a_byte_quiet: assert property (p_byte_quiet) else $error("pin driven in byte mode");

  property p_reset_quiet;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && !dev_reset_n_in) |=> db_oe_n_out == '1;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pin driven during device reset");

  property p_invalid_quiet;
    @(posedge clk_in) disable iff (!reset_n_in)
    !straps_valid_out |-> db_oe_n_out == '1;
  endproperty
  a_invalid_quiet: assert property (p_invalid_quiet) else $error("pin driven before straps captured");

  property p_cfg_quiet;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && (q_reg.mode != MODE_SER || hw_mode || !drive_ok)) |=> !serial_cfg_out;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("config input passed outside software serial");

  property p_lane_b_two;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && drive_ok && q_reg.mode == MODE_SER && !q_reg.single_lane) |=>
      !db_oe_n_out[DB_SERIAL_B] && db_out[DB_SERIAL_B] == $past(serial_b_bit_in);
  endproperty
  a_lane_b_two: assert property (p_lane_b_two) else $error("lane B not driven in two lane use");

  property p_par_idle;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.mode == MODE_PAR && !par_rd_in) |=> db_oe_n_out == '1;
  endproperty
  a_par_idle: assert property (p_par_idle) else $error("parallel bits driven without request");

  property p_ser_quiet;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && q_reg.mode == MODE_SER) |=>
      db_oe_n_out[DB_BYTE_STRAP] && db_oe_n_out[DB_SERIAL_CFG] && (&db_oe_n_out[DB_WIDTH-1:DB_OSR_LSB]);
  endproperty
  a_ser_quiet: assert property (p_ser_quiet) else $error("serial mode drives a non-lane pin");

  property p_sw_write;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == SW_RANGE_OFS &&
      pwdata_in[1:0] != RANGE_SW_CODE && !full_rel && !part_rel) |=> q_reg.sw_range == $past(pwdata_in[1:0]);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software range write lost");

  property p_part_keep;
    @(posedge clk_in) disable iff (!reset_n_in)
    (ce_in && part_rel) |=> q_reg.sw_range == SW_RANGE_RESET && $stable(q_reg.code) && $stable(q_reg.valid);
  endproperty
  a_part_keep: assert property (p_part_keep) else $error("partial reset touched the straps");

  c_serial_two: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    q_reg.mode == MODE_SER && !q_reg.single_lane && !db_oe_n_out[DB_SERIAL_B]);
  c_byte: cover property (@(posedge clk_in) disable iff (!reset_n_in) q_reg.valid && q_reg.mode == MODE_BYTE);
  c_hw_10v: cover property (@(posedge clk_in) disable iff (!reset_n_in) hw_mode && range_sel_out == RANGE_10V);
endmodule

// File: spm_host_model.sv
// host-side partner: drives the reset pin, the straps and its share of the data pins
// assumes the device drives a pin only while its active-low enable is low
`timescale 1ns/10ps
module spm_host_model (
  input wire logic clk_in,
  input wire logic [6:0] dev_db_in,
  input wire logic [6:0] dev_oe_n_in,
  output logic dev_reset_n_out,
  output logic serial_mode_out,
  output logic single_lane_out,
  output logic [1:0] range_code_out,
  output logic [6:0] db_pin_out
);
  logic [6:0] drv_en = 7'h00;
  logic [6:0] drv_val = 7'h00;
  logic [6:0] float_val = 7'h2A;

  initial begin
    dev_reset_n_out = 1'b1;
    serial_mode_out = 1'b0;
    single_lane_out = 1'b0;
    range_code_out = 2'h0;
  end

  // undriven lines keep no value, so they toggle every cycle
  always @(posedge clk_in) begin
    float_val <= ~float_val;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      db_pin_out[i] = !dev_oe_n_in[i] ? dev_db_in[i] : (drv_en[i] ? drv_val[i] : float_val[i]);
    end
  end

  // low time picks full or partial
  task automatic pulse(input int low, input logic [6:0] straps, input logic sm, input logic sl,
                       input logic [1:0] code, input logic [6:0] keep_en, input logic [6:0] keep_val);
    @(posedge clk_in);
    drv_en <= 7'h7F;
    drv_val <= straps;
    serial_mode_out <= sm;
    single_lane_out <= sl;
    range_code_out <= code;
    dev_reset_n_out <= 1'b0;
    repeat (low) @(posedge clk_in);
    dev_reset_n_out <= 1'b1;
    // straps held past the capture edge
    repeat (3) @(posedge clk_in);
    // config input and lanes grounded in byte mode
    drv_en <= keep_en;
    drv_val <= keep_val;
  endtask

  task automatic set_range(input logic [1:0] code);
    @(posedge clk_in);
    range_code_out <= code;
  endtask
endmodule

// File: spm_strap_pin_mode_latch_bench.sv
// self-checking bench for the strap latch: strap capture, pin steering, apb registers
// assumes spm_pkg, spm_top and spm_host_model are compiled first
`timescale 1ns/10ps
module spm_strap_pin_mode_latch_bench;
  import spm_pkg::*;
  localparam int FC = 4;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic dev_reset_n, serial_mode, single_lane, serial_cfg, hw_mode, single_q, valid, pready, pslverr, er;
  logic [1:0] range_code, range_sel;
  logic [6:0] db_pin, db_out, db_oe_n;
  logic [2:0] oversampling_ratio, mode;
  logic par_rd = 1'b0;
  logic [6:0] par_data = 7'h00;
  logic sa = 1'b0;
  logic sb = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  int miscompares = 0;
  int n_checks = 0;

  always #5 clk_in = ~clk_in;

  spm_host_model host (.clk_in(clk_in), .dev_db_in(db_out), .dev_oe_n_in(db_oe_n),
    .dev_reset_n_out(dev_reset_n), .serial_mode_out(serial_mode), .single_lane_out(single_lane),
    .range_code_out(range_code), .db_pin_out(db_pin));

  spm_top #(.FULL_CYCLES(FC)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .dev_reset_n_in(dev_reset_n), .serial_mode_strap_in(serial_mode), .single_lane_strap_in(single_lane),
    .range_mode_pin_hi_in(range_code[1]), .range_mode_pin_lo_in(range_code[0]), .db_in(db_pin),
    .db_out(db_out), .db_oe_n_out(db_oe_n), .par_rd_in(par_rd), .par_data_in(par_data),
    .serial_a_bit_in(sa), .serial_b_bit_in(sb), .serial_cfg_out(serial_cfg), .hw_mode_out(hw_mode),
    .range_sel_out(range_sel), .oversampling_ratio_out(oversampling_ratio), .iface_mode_out(mode),
    .single_lane_out(single_q), .straps_valid_out(valid), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // outputs read at an edge show the state before that edge's updates
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    settle(2);
    chk(db_oe_n, 7'h7F);
    chk(valid, 1'b0);
    // byte mode, oversampling 101, software range
    host.pulse(FC + 2, 7'h51, 1'b0, 1'b0, 2'h0, 7'h0E, 7'h00);
    par_rd <= 1'b1;
    settle(3);
    chk(mode, MODE_BYTE);
    chk(oversampling_ratio, 3'h5);
    chk(hw_mode, 1'b0);
    chk(db_oe_n, 7'h7F);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, {20'h0, 2'h3, 1'b0, 2'h0, 3'h5, 1'b0, 1'b0, 1'b1, 1'b1});
    apb(1'b1, SW_RANGE_OFS, 32'h1);
    apb(1'b1, SW_RANGE_OFS, 32'h0);
    settle(2);
    chk(range_sel, RANGE_2V5);
    host.set_range(2'h2);
    settle(3);
    chk(range_sel, RANGE_2V5);
    chk(hw_mode, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, {20'h0, 2'h1, 1'b0, 2'h0, 3'h5, 1'b0, 1'b0, 1'b1, 1'b1});
    // parallel mode, hardware range 2.5 V
    par_rd <= 1'b0;
    host.pulse(FC + 2, 7'h00, 1'b0, 1'b0, 2'h1, 7'h00, 7'h00);
    settle(3);
    chk(mode, MODE_PAR);
    chk(hw_mode, 1'b1);
    chk(range_sel, RANGE_2V5);
    par_rd <= 1'b1;
    par_data <= 7'h55;
    settle(2);
    chk(db_oe_n, 7'h00);
    chk(db_pin, 7'h55);
    par_rd <= 1'b0;
    settle(2);
    chk(db_oe_n, 7'h7F);
    for (int c = 2; c <= 4; c++) begin
      host.set_range(c[1:0]);
      settle(3);
      chk(range_sel, (c == 4) ? RANGE_10V : c[1:0]);
    end
    // partial reset must not recapture
    host.pulse(1, 7'h01, 1'b1, 1'b0, 2'h0, 7'h00, 7'h00);
    settle(3);
    chk(mode, MODE_PAR);
    chk(oversampling_ratio, 3'h0);
    // serial mode, both lanes, software range
    host.pulse(FC + 2, 7'h30, 1'b1, 1'b0, 2'h0, 7'h02, 7'h02);
    settle(3);
    chk({mode, oversampling_ratio, single_q}, {MODE_SER, 3'h3, 1'b0});
    sa <= 1'b1;
    sb <= 1'b0;
    settle(2);
    chk({db_oe_n[3:2], db_pin[3:2]}, 4'h2);
    chk(serial_cfg, 1'b1);
    sa <= 1'b0;
    sb <= 1'b1;
    settle(2);
    chk(db_pin[3:2], 2'h1);
    // serial mode, lane A only
    host.pulse(FC + 2, 7'h70, 1'b1, 1'b1, 2'h0, 7'h02, 7'h00);
    sa <= 1'b1;
    settle(3);
    chk({oversampling_ratio, single_q}, {3'h7, 1'b1});
    chk({db_oe_n[3:2], db_pin[3]}, 3'h3);
    chk(serial_cfg, 1'b0);
    print_verdict();
  end
endmodule
